// ==== src/smbsl_pkg.sv ====
// Shared constants and types of the SMBus slave port.
package smbsl_pkg;

    // Slave addresses: 7'b0101110, 7'b0101100, 7'b0101101, 7'b0001100.
    localparam logic [6:0] SMBSL_ADDR_FIXED = 7'h2E;
    localparam logic [6:0] SMBSL_ADDR_SEL_0 = 7'h2C;
    localparam logic [6:0] SMBSL_ADDR_SEL_1 = 7'h2D;
    localparam logic [6:0] SMBSL_ADDR_ARA   = 7'h0C;

    localparam logic       SMBSL_DIR_READ   = 1'h1;
    localparam logic [3:0] SMBSL_BYTE_BITS  = 4'h8;
    localparam logic [1:0] SMBSL_PTR_BYTE   = 2'h0;
    localparam logic [1:0] SMBSL_DATA_BYTE  = 2'h1;
    localparam logic [1:0] SMBSL_MAX_BYTES  = 2'h2;
    localparam logic       SMBSL_SDA_LOW    = 1'h0;

    // Bus idle timeout: least time in microseconds, clock in MHz.
    localparam int SMBSL_TOUT_MIN_US = 15000;
    localparam int SMBSL_CLK_MHZ     = 250;
    localparam int SMBSL_TOUT_CYC    = SMBSL_TOUT_MIN_US * SMBSL_CLK_MHZ;
    localparam int SMBSL_TOUT_W      = 23;

    localparam int SMBSL_STATUS_W    = 8;

    typedef enum logic [2:0] {
        SMBSL_IDLE,
        SMBSL_ADDR,
        SMBSL_ADDR_ACK,
        SMBSL_WR_BYTE,
        SMBSL_WR_ACK,
        SMBSL_RD_BYTE,
        SMBSL_RD_ACK
    } smbsl_state_t;

endpackage

// ==== src/smbsl_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous inputs.
module smbsl_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset and enable.
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    // Data.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // smbsl_sync

`default_nettype wire

// ==== src/smbsl_slave.sv ====
// What this block does
// - Strap-enable high at the first start after reset gives fixed address 0101110.
// - Strap-enable low: select strap picks address 0101100 or 0101101.
// - Address is latched at the first start condition after reset, whether or not it matches; later strap changes ignored.
// - After address assignment the strap pins return to PWM and tach duty.
// - Start is SDA falling while SCL high; device then receives a byte.
// - After start, eight bits shift in: address MSB first, then direction.
// - On address match, SDA is held low from before the ninth clock through it.
// - Direction 0 means master writes; direction 1 means master reads.
// - On mismatch the device stays idle with SDA released until next start.
// - Each byte is nine clocks: eight data bits and one acknowledge.
// - SDA changes only with SCL low; SDA rising with SCL high is stop.
// - Direction is fixed by the first byte until a new start.
// - Writes take one or two bytes; a read returns exactly one byte.
// - First written byte always goes into the address pointer.
// - Second written byte goes into the register the pointer selects.
// - A read returns the pointed register; the pointer keeps its value.
// - In alert mode the shared PWM pin goes low on any unmasked status bit.
// - Masks gate only the alert pin; status bits still set.
// - While alert is low, a read of 0001100 returns the own address.
// - With timeout enabled, TOUT_CYC clocks (15 ms by default) without activity outside idle releases the bus.
`timescale 1ns/10ps
`default_nettype none

module smbsl_slave
    import smbsl_pkg::*;
#(
    parameter int TOUT_CYC = smbsl_pkg::SMBSL_TOUT_CYC,
    parameter int STATUS_W = smbsl_pkg::SMBSL_STATUS_W
) (
    // Clock, reset and enable.
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                ce_i,
    // SMBus pins; SDA is open drain.
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_o,
    // Fan 3 PWM pin, also the address-strap enable.
    input  wire logic                fan3_pwm_pin_i,
    input  wire logic                fan3_pwm_out_i,
    output logic                     fan3_pwm_pin_oe_o,
    // Fan 4 tach pin, also the address-select strap.
    input  wire logic                fan4_tach_in_i,
    output logic                     fan4_tach_o,
    // Fan 2 PWM pin, or alert output.
    input  wire logic                fan2_pwm_out_i,
    input  wire logic                alert_mode_i,
    output logic                     fan2_pwm_pin_oe_o,
    // Limit status events, clears and masks.
    input  wire logic [STATUS_W-1:0] limit_evt_i,
    input  wire logic [STATUS_W-1:0] status_clr_i,
    input  wire logic [STATUS_W-1:0] alert_mask_i,
    output logic      [STATUS_W-1:0] status_o,
    output logic                     alert_o,
    // Configuration.
    input  wire logic                bus_timeout_disable_i,
    // Internal register access.
    output logic      [7:0]          reg_ptr_o,
    output logic                     reg_wr_o,
    output logic      [7:0]          reg_wdata_o,
    input  wire logic [7:0]          reg_rdata_i,
    // Address status.
    output logic      [6:0]          slave_addr_o,
    output logic                     addr_valid_o
);

    import smbsl_pkg::*;

    typedef struct packed {
        smbsl_state_t              st;
        logic                      scl_p;
        logic                      sda_p;
        logic [3:0]                bits;
        logic [7:0]                sh;
        logic [7:0]                tx;
        logic [1:0]                nbytes;
        logic [7:0]                ptr;
        logic                      wr;
        logic [7:0]                wdata;
        logic [6:0]                addr;
        logic                      assigned;
        logic                      sda_oe;
        logic                      sda_out;
        logic [SMBSL_TOUT_W-1:0]   tout;
        logic [STATUS_W-1:0]       status;
        logic                      alert;
        logic                      fan3_pwm_out_oe;
        logic                      fan2_pwm_out_oe;
        logic                      tach;
    } smbsl_regs_t;

    localparam logic [SMBSL_TOUT_W-1:0] TOUT_LAST = SMBSL_TOUT_W'(TOUT_CYC - 1);

    logic [4:0]  sync_in;
    logic        scl_s;
    logic        sda_s;
    logic        strap_en_s;
    logic        strap_sel_s;
    logic        tach_s;
    smbsl_regs_t q;
    smbsl_regs_t d;

    smbsl_sync #(
        .WIDTH (5)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .async_i    ({scl_i, sda_i, fan3_pwm_pin_i, fan4_tach_in_i, fan4_tach_in_i}),
        .sync_o     (sync_in)
    );

    assign scl_s       = sync_in[4];
    assign sda_s       = sync_in[3];
    assign strap_en_s  = sync_in[2];
    assign strap_sel_s = sync_in[1];
    assign tach_s      = sync_in[0];

    always_comb begin
        logic       start;
        logic       stop;
        logic       rise;
        logic       fall;
        logic [6:0] own;
        logic       hit;
        logic       ara_hit;
        start   = 1'b0;
        stop    = 1'b0;
        rise    = 1'b0;
        fall    = 1'b0;
        own     = q.addr;
        hit     = 1'b0;
        ara_hit = 1'b0;
        d       = q;
        d.wr    = 1'b0;
        d.scl_p = scl_s;
        d.sda_p = sda_s;

        start = q.scl_p && scl_s && q.sda_p && !sda_s;
        stop  = q.scl_p && scl_s && !q.sda_p && sda_s;
        rise  = !q.scl_p && scl_s;
        fall  = q.scl_p && !scl_s;

        // The strap is caught once, at the first start seen after reset.
        if (!q.assigned) begin
            if (strap_en_s) begin
                own = SMBSL_ADDR_FIXED;
            end else if (strap_sel_s) begin
                own = SMBSL_ADDR_SEL_1;
            end else begin
                own = SMBSL_ADDR_SEL_0;
            end
        end
        if (start && !q.assigned) begin
            d.addr     = own;
            d.assigned = 1'b1;
        end

        case (q.st)
            SMBSL_IDLE: begin
                d.sda_oe = 1'b0;
            end
            SMBSL_ADDR: begin
                if (rise) begin
                    d.sh   = {q.sh[6:0], sda_s};
                    d.bits = q.bits + 4'h1;
                end else if (fall && q.bits == SMBSL_BYTE_BITS) begin
                    hit     = q.sh[7:1] == own;
                    ara_hit = q.sh[7:1] == SMBSL_ADDR_ARA && q.alert && alert_mode_i
                              && q.sh[0] == SMBSL_DIR_READ;
                    if (hit || ara_hit) begin
                        d.sda_oe = 1'b1;
                        d.st     = SMBSL_ADDR_ACK;
                        d.tx     = ara_hit ? {own, 1'b0} : reg_rdata_i;
                    end else begin
                        d.st = SMBSL_IDLE;
                    end
                end
            end
            SMBSL_ADDR_ACK: begin
                if (fall) begin
                    d.bits   = '0;
                    d.nbytes = SMBSL_PTR_BYTE;
                    if (q.sh[0] == SMBSL_DIR_READ) begin
                        d.st     = SMBSL_RD_BYTE;
                        d.sda_oe = !q.tx[7];
                        d.tx     = {q.tx[6:0], 1'b1};
                    end else begin
                        d.st     = SMBSL_WR_BYTE;
                        d.sda_oe = 1'b0;
                    end
                end
            end
            SMBSL_WR_BYTE: begin
                if (rise) begin
                    d.sh   = {q.sh[6:0], sda_s};
                    d.bits = q.bits + 4'h1;
                end else if (fall && q.bits == SMBSL_BYTE_BITS) begin
                    if (q.nbytes == SMBSL_PTR_BYTE) begin
                        d.ptr    = q.sh;
                        d.sda_oe = 1'b1;
                        d.st     = SMBSL_WR_ACK;
                    end else if (q.nbytes == SMBSL_DATA_BYTE) begin
                        d.wr     = 1'b1;
                        d.wdata  = q.sh;
                        d.sda_oe = 1'b1;
                        d.st     = SMBSL_WR_ACK;
                    end else begin
                        d.st = SMBSL_IDLE;
                    end
                end
            end
            SMBSL_WR_ACK: begin
                if (fall) begin
                    d.sda_oe = 1'b0;
                    d.bits   = '0;
                    d.nbytes = (q.nbytes == SMBSL_MAX_BYTES) ? q.nbytes : q.nbytes + 2'h1;
                    d.st     = SMBSL_WR_BYTE;
                end
            end
            SMBSL_RD_BYTE: begin
                if (rise) begin
                    d.bits = q.bits + 4'h1;
                end else if (fall) begin
                    if (q.bits == SMBSL_BYTE_BITS) begin
                        d.sda_oe = 1'b0;
                        d.st     = SMBSL_RD_ACK;
                    end else begin
                        d.sda_oe = !q.tx[7];
                        d.tx     = {q.tx[6:0], 1'b1};
                    end
                end
            end
            SMBSL_RD_ACK: begin
                // Exactly one byte per read, so either answer ends the transfer.
                if (rise) begin
                    d.st = SMBSL_IDLE;
                end
                d.sda_oe = 1'b0;
            end
            default: begin
                d.st     = SMBSL_IDLE;
                d.sda_oe = 1'b0;
            end
        endcase

        // Start and stop override any byte phase.
        if (start) begin
            d.st     = SMBSL_ADDR;
            d.bits   = '0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st     = SMBSL_IDLE;
            d.sda_oe = 1'b0;
        end

        // Idle-bus watchdog; any line change restarts it.
        if (q.st == SMBSL_IDLE || bus_timeout_disable_i || rise || fall
            || q.sda_p != sda_s) begin
            d.tout = '0;
        end else if (q.tout == TOUT_LAST) begin
            d.tout   = '0;
            d.st     = SMBSL_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            d.tout = q.tout + 1'b1;
        end

        // Sticky status: a new event wins over a clear in the same cycle.
        d.status  = (q.status & ~status_clr_i) | limit_evt_i;
        d.alert   = |(d.status & ~alert_mask_i);
        d.fan2_pwm_out_oe = alert_mode_i ? d.alert : !fan2_pwm_out_i;
        d.fan3_pwm_out_oe = d.assigned && !fan3_pwm_out_i;
        d.tach    = d.assigned && tach_s;
        d.sda_out = SMBSL_SDA_LOW;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign sda_o             = q.sda_out;
    assign sda_oe_o          = q.sda_oe;
    assign fan3_pwm_pin_oe_o = q.fan3_pwm_out_oe;
    assign fan4_tach_o       = q.tach;
    assign fan2_pwm_pin_oe_o = q.fan2_pwm_out_oe;
    assign status_o          = q.status;
    assign alert_o           = q.alert;
    assign reg_ptr_o         = q.ptr;
    assign reg_wr_o          = q.wr;
    assign reg_wdata_o       = q.wdata;
    assign slave_addr_o      = q.addr;
    assign addr_valid_o      = q.assigned;

endmodule // smbsl_slave

`default_nettype wire

// ==== dv/smbsl_slave_sva.sv ====
`timescale 1ns/10ps
`default_nettype none

module smbsl_slave_sva
    import smbsl_pkg::*;
#(
    parameter int TOUT_CYC = 200,
    parameter int STATUS_W = 8
) (
    // Clock and reset.
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    // Bus and strap pins.
    input  wire logic                scl_i,
    input  wire logic                sda_oe_o,
    input  wire logic                fan3_pwm_pin_i,
    input  wire logic                fan3_pwm_out_i,
    input  wire logic                fan3_pwm_pin_oe_o,
    input  wire logic                fan4_tach_in_i,
    // Status and alert.
    input  wire logic [STATUS_W-1:0] limit_evt_i,
    input  wire logic [STATUS_W-1:0] status_clr_i,
    input  wire logic [STATUS_W-1:0] alert_mask_i,
    input  wire logic [STATUS_W-1:0] status_o,
    input  wire logic                alert_o,
    // Register access and address.
    input  wire logic                reg_wr_o,
    input  wire logic [6:0]          slave_addr_o,
    input  wire logic                addr_valid_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sda_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line drive changed while clock high");
    idle_release_a: assert property (!addr_valid_o |-> !sda_oe_o)
        else $error("data line driven before any address match");
    addr_hold_a: assert property ($past(addr_valid_o) |-> $stable(slave_addr_o))
        else $error("latched address changed");
    addr_fixed_a: assert property ($rose(addr_valid_o) && fan3_pwm_pin_i
        |-> slave_addr_o == SMBSL_ADDR_FIXED) else $error("fixed address wrong");
    addr_select_a: assert property ($rose(addr_valid_o) && !fan3_pwm_pin_i
        |-> slave_addr_o == (fan4_tach_in_i ? SMBSL_ADDR_SEL_1 : SMBSL_ADDR_SEL_0))
        else $error("selected address wrong");
    strap_hold_a: assert property (!addr_valid_o |-> !fan3_pwm_pin_oe_o)
        else $error("strap pin driven before address assigned");
    strap_pwm_a: assert property (addr_valid_o && $past(addr_valid_o)
        |-> fan3_pwm_pin_oe_o == !$past(fan3_pwm_out_i)) else $error("pwm pin not restored");
    status_sticky_a: assert property (status_o ==
        (($past(status_o) & ~$past(status_clr_i)) | $past(limit_evt_i)))
        else $error("status bits wrong");
    alert_level_a: assert property (alert_o == |(status_o & ~$past(alert_mask_i)))
        else $error("alert level wrong");
    write_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("register write longer than one cycle");

    cover property ($rose(reg_wr_o));
    cover property ($rose(alert_o));
    cover property ($rose(addr_valid_o));
endmodule // smbsl_slave_sva

bind smbsl_slave smbsl_slave_sva #(.TOUT_CYC(TOUT_CYC), .STATUS_W(STATUS_W)) i_sva (
    .core_clk_i, .nrst_i, .scl_i, .sda_oe_o, .fan3_pwm_pin_i, .fan3_pwm_out_i,
    .fan3_pwm_pin_oe_o, .fan4_tach_in_i, .limit_evt_i, .status_clr_i, .alert_mask_i,
    .status_o, .alert_o, .reg_wr_o, .slave_addr_o, .addr_valid_o
);

`default_nettype wire

// ==== dv/smbsl_host.sv ====
`timescale 1ns/10ps
`default_nettype none

// Behavioural SMBus host; SDA output high means released, the line has a pull-up.
module smbsl_host (
    // Bus lines.
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    localparam realtime QTR = 16.0;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic start();
        #0.7 sda_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b0;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sda_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b1;
        #QTR;
    endtask

    // Data settles mid low phase and is sampled mid high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        #QTR scl_o = 1'b1;
        #QTR r = sda_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ack_b, output logic [7:0] r,
                           output logic ack_r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_b, ack_r);
    endtask
endmodule // smbsl_host

`default_nettype wire

// ==== dv/smbsl_slave_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module smbsl_slave_tb_top;
    import smbsl_pkg::*;
    localparam int         TOUT      = 200;
    localparam logic [6:0] ADDRS [3] = '{SMBSL_ADDR_FIXED, SMBSL_ADDR_SEL_0, SMBSL_ADDR_SEL_1};
    logic       core_clk_i;
    logic       nrst_i    = 1'b0;
    logic       strap_en  = 1'b1;
    logic       strap_sel = 1'b0;
    logic       fan3_pwm_out      = 1'b0;
    logic       amode     = 1'b0;
    logic       tout_dis  = 1'b0;
    logic [7:0] evt       = 8'h00;
    logic [7:0] clr       = 8'h00;
    logic [7:0] mask      = 8'h00;
    logic [7:0] regs [256];
    logic [7:0] ptr, wdata, status;
    logic [6:0] own;
    logic       scl, sda_host, sda_val, sda_oe, sda_line, wr, fan3_pwm_out_oe, tach, fan2_pwm_out_oe, alert, valid;
    int         errors     = 0;
    int         n_compared = 0;
    int         cycles     = 0;

    assign sda_line = sda_host & (sda_oe ? sda_val : 1'b1);

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (wr) regs[ptr] <= wdata;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    smbsl_slave #(.TOUT_CYC(TOUT), .STATUS_W(8)) i_dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_val), .sda_oe_o(sda_oe),
        .fan3_pwm_pin_i(strap_en), .fan3_pwm_out_i(fan3_pwm_out), .fan3_pwm_pin_oe_o(fan3_pwm_out_oe),
        .fan4_tach_in_i(strap_sel), .fan4_tach_o(tach),
        .fan2_pwm_out_i(1'b1), .alert_mode_i(amode), .fan2_pwm_pin_oe_o(fan2_pwm_out_oe),
        .limit_evt_i(evt), .status_clr_i(clr), .alert_mask_i(mask), .status_o(status),
        .alert_o(alert), .bus_timeout_disable_i(tout_dis), .reg_ptr_o(ptr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rdata_i(regs[ptr]), .slave_addr_o(own), .addr_valid_o(valid)
    );

    smbsl_host i_host (.scl_o(scl), .sda_o(sda_host), .sda_i(sda_line));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic do_reset(input logic en, input logic sel);
        step(1);
        nrst_i = 1'b0;
        strap_en = en;
        strap_sel = sel;
        step(3);
        nrst_i = 1'b1;
        step(4);
    endtask

    task automatic pulse(input logic [7:0] e, input logic [7:0] c);
        evt = e;
        clr = c;
        step(1);
        evt = 8'h00;
        clr = 8'h00;
        step(3);
    endtask

    // Bit i+1 of acks is set when data byte i was acknowledged.
    task automatic write_op(input logic [6:0] a, input logic [23:0] b, input int n,
                            input logic stop, output logic [3:0] acks);
        logic [7:0] r;
        logic       x;
        i_host.start();
        i_host.byte_io({a, 1'b0}, 1'b1, r, x);
        acks = {3'h0, !x};
        for (int i = 0; i < n; i++) begin
            i_host.byte_io(b[23-8*i -: 8], 1'b1, r, x);
            acks[i+1] = !x;
        end
        if (stop) i_host.stop();
    endtask

    task automatic read_op(input logic [6:0] a, output logic [7:0] d, output logic ack);
        logic [7:0] r;
        logic       x;
        i_host.start();
        i_host.byte_io({a, 1'b1}, 1'b1, r, x);
        ack = !x;
        i_host.byte_io(8'hFF, 1'b1, d, x);
        i_host.stop();
    endtask

    initial begin
        logic [7:0] r;
        logic       x;
        logic [3:0] acks;
        logic [6:0] a;
        for (int k = 0; k < 3; k++) begin
            a = ADDRS[k];
            do_reset(k == 0, k == 2);
            check(tach, 1'b0);
            check(valid, 1'b0);
            fan3_pwm_out = k[0];
            write_op(a, {8'h20 + k[7:0], 8'h31 + k[7:0], 8'h00}, 2, 1'b1, acks);
            check(acks, 4'h7);
            check(ptr, 8'h20 + k[7:0]);
            check(regs[8'h20 + k[7:0]], 8'h31 + k[7:0]);
            check(own, a);
            step(1);
            strap_en = !strap_en;
            strap_sel = !strap_sel;
            write_op(ADDRS[(k + 1) % 3], 24'h7F0000, 1, 1'b1, acks);
            check(acks, 4'h0);
            check(ptr, 8'h20 + k[7:0]);
            repeat (2) begin
                read_op(a, r, x);
                check(x, 1'b1);
                check(r, 8'h31 + k[7:0]);
            end
            check(own, a);
            check(fan3_pwm_out_oe, !fan3_pwm_out);
            check(tach, strap_sel);
        end
        regs[8'h40] = 8'h6C;
        write_op(a, 24'h400000, 1, 1'b0, acks);
        check(acks, 4'h3);
        read_op(a, r, x);
        check(r, 8'h6C);
        write_op(a, 24'h411122, 3, 1'b1, acks);
        check(acks, 4'h7);
        check(regs[8'h41], 8'h11);
        step(1);
        amode = 1'b1;
        mask = 8'h04;
        pulse(8'h04, 8'h00);
        check(status, 8'h04);
        check(fan2_pwm_out_oe, 1'b0);
        pulse(8'h01, 8'h00);
        check(alert, 1'b1);
        check(fan2_pwm_out_oe, 1'b1);
        read_op(SMBSL_ADDR_ARA, r, x);
        check(x, 1'b1);
        check(r, {a, 1'b0});
        step(1);
        pulse(8'h00, 8'h05);
        check(status, 8'h00);
        check(fan2_pwm_out_oe, 1'b0);
        read_op(SMBSL_ADDR_ARA, r, x);
        check(x, 1'b0);
        // After the next reset the pointer is zero, so register zero needs a zero bit 7.
        regs[8'h00] = 8'h00;
        // Stall in the low phase while the device drives a zero data bit.
        for (int dis = 0; dis < 2; dis++) begin
            step(1);
            tout_dis = dis[0];
            i_host.start();
            i_host.byte_io({a, 1'b1}, 1'b1, r, x);
            step(150);
            check(sda_oe, 1'b1);
            step(150);
            check(sda_oe, dis[0]);
            do_reset(1'b0, 1'b1);
            i_host.stop();
        end
        finish_test();
    end
endmodule // smbsl_slave_tb_top

`default_nettype wire
